/* File: design/icsc_pkg.sv */
// Purpose: Shared constants for input current sense calibration
// Assumes: 10 MHz reference clock, word-level management transactions
// Notes:   Command codes, field positions, reset values, scaling tables
package icsc_pkg;
  // Command codes
  localparam logic [7:0] CMD_PAGE     = 8'h00;
  localparam logic [7:0] CMD_IIN      = 8'h89;
  localparam logic [7:0] CMD_VOUT_LIN = 8'hD4;
  localparam logic [7:0] CMD_CFG10    = 8'hDA;
  localparam logic [7:0] CMD_CFG12    = 8'hDC;
  // Page codes
  localparam logic [7:0] PAGE_A = 8'h00;
  localparam logic [7:0] PAGE_B = 8'h01;
  // Field positions
  localparam int DGS_LSB   = 8;
  localparam int CEIL_LSB  = 0;
  localparam int BOOST_BIT = 13;
  localparam int OFS_LSB   = 8;
  localparam int SEL_LSB   = 14;
  localparam int FACT_LSB  = 0;
  // Values after reset, before the stored values load
  localparam logic [7:0]  PAGE_RST  = 8'h00;
  localparam logic [7:0]  DGS_RST   = 8'h32;
  localparam logic [7:0]  CEIL_RST  = 8'h00;
  localparam logic [4:0]  OFS_RST   = 5'h00;
  localparam logic [1:0]  SEL_RST   = 2'h0;
  localparam logic [12:0] FACT_RST  = 13'h0000;
  localparam logic [15:0] WORD_RST  = 16'h0000;
  // Digital gain scale limit
  localparam logic [7:0] DGS_MAX = 8'h40;
  // Refresh period of the input current readback
  localparam int REFRESH_NS  = 100000;
  localparam int CLK_NS      = 100;
  localparam int REFRESH_CYC = REFRESH_NS / CLK_NS;
  localparam int CALC_LAT    = 3;
  // Linear format: exponent -4, so one mantissa step is 1/16 A
  localparam logic [4:0]         LIN_EXP  = 5'h1C;
  localparam logic signed [10:0] MANT_MAX = 11'sh3FF;
  localparam logic signed [10:0] MANT_MIN = -11'sh400;
  // 160*65536/gain in micro-ohm, index {boost, select}
  localparam logic [7:0][16:0] GAIN_RECIP = {
    17'h0_0A3D, 17'h0_1111, 17'h0_147B, 17'h0_2222,
    17'h0_51EC, 17'h0_8889, 17'h0_A3D7, 17'h1_1111};
  // Largest sense voltage in microvolts, index select
  localparam logic [3:0][15:0] SENSE_MAX_UV = {
    16'h61A8, 16'h3A98, 16'h30D4, 16'h1D4C};
  // 65536/50, 65536/10, and 0.1 A in 1/160 A
  localparam logic [11:0] DGS_RECIP   = 12'h51F;
  localparam logic [12:0] TENTH_RECIP = 13'h199A;
  localparam int          OFS_STEP_SH = 4;
endpackage

/* File: design/icsc_calc.sv */
// Purpose: Pipelined input current computation in linear format
// Assumes: Sense sample in microvolts, same clock domain
// Notes:   Three register stages from start to done
`timescale 1ns/1ps
module icsc_calc (
  // Clock and reset
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  input  wire logic               ce_in,
  // Operands
  input  wire logic               start_in,
  input  wire logic signed [15:0] uv_in,
  input  wire logic [2:0]         gain_code_in,
  input  wire logic [7:0]         dgs_in,
  input  wire logic [4:0]         ofs_in,
  // Result
  output logic                    done_out,
  output logic signed [10:0]      mant_out,
  output logic                    clip_out
);
  logic signed [33:0] p1_q, p1_d;
  logic signed [42:0] t_q, t_d;
  logic signed [23:0] ofs_q, ofs_d;
  logic [2:0]         vld_q, vld_d;
  logic signed [10:0] mant_q, mant_d;
  logic               clip_q, clip_d, clip1_q, clip1_d;
  logic [7:0]         dgs1_q, dgs1_d;
  logic signed [15:0] lim;
  logic signed [15:0] uv_c;
  logic signed [55:0] p3;
  logic signed [23:0] u;
  logic signed [37:0] p4;
  logic signed [21:0] mf;

  // Next values of the three stages
  always_comb begin
    lim     = $signed(icsc_pkg::SENSE_MAX_UV[gain_code_in[1:0]]);
    uv_c    = uv_in;
    clip1_d = clip1_q;
    if (uv_in > lim) begin // R03
      uv_c    = lim;
    end else if (uv_in < -lim) begin // R03
      uv_c    = -lim;
    end
    // Flag and offset taken with the operands, held to the output stage
    if (start_in) begin
      clip1_d = (uv_c != uv_in); // R03
    end
    p1_d   = uv_c * $signed({1'b0, icsc_pkg::GAIN_RECIP[gain_code_in]}); // R02
    dgs1_d = dgs_in;
    t_d    = p1_q * $signed({1'b0, dgs1_q}); // R04
    ofs_d  = ofs_q;
    if (start_in) begin
      ofs_d = {{19{ofs_in[4]}}, ofs_in} << icsc_pkg::OFS_STEP_SH; // R08
    end
    p3     = t_q * $signed({1'b0, icsc_pkg::DGS_RECIP});
    u      = p3[55:32] + ofs_q; // R19
    p4     = u * $signed({1'b0, icsc_pkg::TENTH_RECIP});
    mf     = p4[37:16];
    clip_d = clip_q;
    mant_d = mant_q;
    vld_d  = {vld_q[1:0], start_in};
    if (vld_q[1]) begin
      clip_d = clip1_q;
      if (mf > icsc_pkg::MANT_MAX) begin
        mant_d = icsc_pkg::MANT_MAX;
      end else if (mf < icsc_pkg::MANT_MIN) begin
        mant_d = icsc_pkg::MANT_MIN;
      end else begin
        mant_d = mf[10:0];
      end
    end
  end

  // Stage registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      p1_q    <= '0;
      t_q     <= '0;
      ofs_q   <= '0;
      vld_q   <= '0;
      mant_q  <= '0;
      clip_q  <= 1'b0;
      clip1_q <= 1'b0;
      dgs1_q  <= '0;
    end else if (ce_in) begin
      p1_q    <= p1_d;
      t_q     <= t_d;
      ofs_q   <= ofs_d;
      vld_q   <= vld_d;
      mant_q  <= mant_d;
      clip_q  <= clip_d;
      clip1_q <= clip1_d;
      dgs1_q  <= dgs1_d;
    end
  end

  assign done_out = vld_q[2];
  assign mant_out = mant_q;
  assign clip_out = clip_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_latency;
    (start_in && ce_in) ##1 ce_in[*2] |=> done_out;
  endproperty
  a_latency: assert property (p_latency) else $error("result not ready three cycles after start"); // R17

  property p_offset_only;
    (start_in && ce_in && uv_in == 16'sh0 && ofs_in == 5'h0A) ##1 ce_in[*2]
      |=> (mant_out == 11'sh010);
  endproperty
  a_offset_only: assert property (p_offset_only) else $error("offset of 1.0 A not reported as 16"); // R08

  property p_full_scale;
    (start_in && ce_in && uv_in == 16'sh61A8 && gain_code_in == 3'h3 && dgs_in == 8'h32 && ofs_in == 5'h00)
      ##1 ce_in[*2] |=> (mant_out == 11'sh320 && !clip_out);
  endproperty
  a_full_scale: assert property (p_full_scale) else $error("25 mV on 0.5 mohm not reported as 50 A"); // R19

  property p_clip;
    (start_in && ce_in && uv_in > 16'sh61A8) ##1 ce_in[*2] |=> clip_out;
  endproperty
  a_clip: assert property (p_clip) else $error("over-range sense voltage not flagged"); // R03
endmodule

/* File: design/icsc_top.sv */
// Purpose: Input current sense calibration registers and readback
// Assumes: Word transactions decoded upstream on the same clock
// Notes:   Stored values load on the first enabled cycle after reset
//
// How it works
// [R01] One input current value is reported for both channels together.
// [R02] Boost bit and two-bit select pick one of eight analog gains.
// [R03] Sense voltage limited per select code; 50 A or 6.25 A full scale.
// [R04] Reported current scales by digital gain scale over fifty.
// [R05] Digital gain scale never exceeds sixty-four.
// [R06] Digital gain scale sits in bits 15:8 of page 0 word.
// [R07] Host sets scale to fifty times analog gain over sense resistance.
// [R08] Five-bit signed offset in page 1 bits 12:8, 0.1 A steps.
// [R09] Boost bit sits in bit 13 of the page 1 word.
// [R10] Each channel has its own current ceiling in bits 7:0, 1 A steps.
// [R11] Page 00h selects channel A, page 01h selects channel B.
// [R12] Gain select in bits 15:14 of gain word, page 0 only.
// [R13] Host selects page 00h before using the gain word.
// [R14] Host leaves factory bits 12:0 of the gain word unchanged.
// [R15] Calibration words use word reads and writes only.
// [R16] Voltage readback is read-only, exponent 15:11, mantissa 10:0.
// [R17] Input current readback refreshes every 100 microseconds, word read only.
// [R18] Input current word holds exponent 15:11 and mantissa 10:0.
// [R19] Current equals voltage over gain, times scale over fifty, plus offset.
// [R20] Fields load from stored values at reset and hold until rewritten.
`timescale 1ns/1ps
module icsc_top #(
  parameter int unsigned REFRESH_CYCLES = icsc_pkg::REFRESH_CYC
) (
  // Clock, reset, enable
  input  wire logic               REF_CLK_IN,
  input  wire logic               RESET_IN,
  input  wire logic               CE_IN,
  // Management transactions
  input  wire logic [7:0]         CMD_CODE_IN,
  input  wire logic               WR_WORD_IN,
  input  wire logic               RD_WORD_IN,
  input  wire logic               WR_BYTE_IN,
  input  wire logic               RD_BYTE_IN,
  input  wire logic [15:0]        WR_DATA_IN,
  output logic [15:0]             RD_DATA_OUT,
  output logic                    RD_VALID_OUT,
  output logic                    INVALID_OUT,
  // Stored defaults
  input  wire logic [15:0]        NVM_CFG_A_IN,
  input  wire logic [15:0]        NVM_CFG_B_IN,
  input  wire logic [15:0]        NVM_GAIN_IN,
  // Telemetry samples
  input  wire logic signed [15:0] SENSE_UV_IN,
  input  wire logic [15:0]        VOUT_LIN_A_IN,
  input  wire logic [15:0]        VOUT_LIN_B_IN,
  // Results and settings
  output logic [15:0]             IIN_WORD_OUT,
  output logic                    IIN_UPDATE_OUT,
  output logic                    SENSE_CLIP_OUT,
  output logic [2:0]              ANALOG_GAIN_CODE_OUT,
  output logic [7:0]              CEIL_A_OUT,
  output logic [7:0]              CEIL_B_OUT,
  output logic [7:0]              PAGE_OUT
);
  if (REFRESH_CYCLES <= icsc_pkg::CALC_LAT || REFRESH_CYCLES > 65535) begin : g_bad_refresh
    $error("REFRESH_CYCLES out of range");
  end

  // Configuration state
  logic        load_pend_q, load_pend_d;
  logic [7:0]  page_q, page_d;
  logic [7:0]  dgs_q, dgs_d;
  logic [7:0]  ceil_a_q, ceil_a_d;
  logic [7:0]  ceil_b_q, ceil_b_d;
  logic        boost_q, boost_d;
  logic [4:0]  ofs_q, ofs_d;
  logic [1:0]  sel_q, sel_d;
  logic [12:0] fact_q, fact_d;
  logic        on_a;
  // Response state
  logic [15:0] rd_data_q, rd_data_d;
  logic        rd_valid_q, rd_valid_d;
  logic        invalid_q, invalid_d;
  // Refresh and readback state
  logic [15:0] ref_cnt_q, ref_cnt_d;
  logic        start_q, start_d;
  logic [15:0] iin_q, iin_d;
  logic        upd_q, upd_d;
  logic        clip_q, clip_d;
  logic        calc_done;
  logic        calc_clip;
  logic signed [10:0] calc_mant;
  // Command classes
  logic        is_word_reg;
  logic        is_known;

  function automatic logic [7:0] clamp_dgs(input logic [7:0] v);
    return (v > icsc_pkg::DGS_MAX) ? icsc_pkg::DGS_MAX : v;
  endfunction

  assign on_a        = (page_q == icsc_pkg::PAGE_A); // R11
  assign is_word_reg = (CMD_CODE_IN == icsc_pkg::CMD_CFG10) || (CMD_CODE_IN == icsc_pkg::CMD_CFG12) ||
                       (CMD_CODE_IN == icsc_pkg::CMD_IIN) || (CMD_CODE_IN == icsc_pkg::CMD_VOUT_LIN);
  assign is_known    = is_word_reg || (CMD_CODE_IN == icsc_pkg::CMD_PAGE);

  // Configuration next values: stored load, page, word writes
  always_comb begin
    load_pend_d = 1'b0;
    page_d      = page_q;
    dgs_d       = dgs_q;
    ceil_a_d    = ceil_a_q;
    ceil_b_d    = ceil_b_q;
    boost_d     = boost_q;
    ofs_d       = ofs_q;
    sel_d       = sel_q;
    fact_d      = fact_q;
    if (load_pend_q) begin // R20
      dgs_d    = clamp_dgs(NVM_CFG_A_IN[icsc_pkg::DGS_LSB +: 8]);
      ceil_a_d = NVM_CFG_A_IN[icsc_pkg::CEIL_LSB +: 8];
      boost_d  = NVM_CFG_B_IN[icsc_pkg::BOOST_BIT];
      ofs_d    = NVM_CFG_B_IN[icsc_pkg::OFS_LSB +: 5];
      ceil_b_d = NVM_CFG_B_IN[icsc_pkg::CEIL_LSB +: 8];
      sel_d    = NVM_GAIN_IN[icsc_pkg::SEL_LSB +: 2];
      fact_d   = NVM_GAIN_IN[icsc_pkg::FACT_LSB +: 13];
    end else if (WR_BYTE_IN && CMD_CODE_IN == icsc_pkg::CMD_PAGE) begin
      if (WR_DATA_IN[7:0] == icsc_pkg::PAGE_A || WR_DATA_IN[7:0] == icsc_pkg::PAGE_B) begin // R11
        page_d = WR_DATA_IN[7:0];
      end
    end else if (WR_WORD_IN && CMD_CODE_IN == icsc_pkg::CMD_CFG10) begin // R15
      if (on_a) begin
        dgs_d    = clamp_dgs(WR_DATA_IN[icsc_pkg::DGS_LSB +: 8]); // R05 R06
        ceil_a_d = WR_DATA_IN[icsc_pkg::CEIL_LSB +: 8]; // R10
      end else begin
        boost_d  = WR_DATA_IN[icsc_pkg::BOOST_BIT]; // R09
        ofs_d    = WR_DATA_IN[icsc_pkg::OFS_LSB +: 5]; // R08
        ceil_b_d = WR_DATA_IN[icsc_pkg::CEIL_LSB +: 8]; // R10
      end
    end else if (WR_WORD_IN && CMD_CODE_IN == icsc_pkg::CMD_CFG12 && on_a) begin // R12
      sel_d  = WR_DATA_IN[icsc_pkg::SEL_LSB +: 2];
      fact_d = WR_DATA_IN[icsc_pkg::FACT_LSB +: 13]; // R14
    end
  end

  // Configuration registers
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      load_pend_q <= 1'b1;
      page_q      <= icsc_pkg::PAGE_RST;
      dgs_q       <= icsc_pkg::DGS_RST;
      ceil_a_q    <= icsc_pkg::CEIL_RST;
      ceil_b_q    <= icsc_pkg::CEIL_RST;
      boost_q     <= 1'b0;
      ofs_q       <= icsc_pkg::OFS_RST;
      sel_q       <= icsc_pkg::SEL_RST;
      fact_q      <= icsc_pkg::FACT_RST;
    end else if (CE_IN) begin
      load_pend_q <= load_pend_d;
      page_q      <= page_d;
      dgs_q       <= dgs_d;
      ceil_a_q    <= ceil_a_d;
      ceil_b_q    <= ceil_b_d;
      boost_q     <= boost_d;
      ofs_q       <= ofs_d;
      sel_q       <= sel_d;
      fact_q      <= fact_d;
    end
  end

  // Response next values: read data and refusals
  always_comb begin
    rd_data_d  = rd_data_q;
    rd_valid_d = 1'b0;
    invalid_d  = 1'b0;
    if (RD_WORD_IN && is_word_reg) begin // R15
      rd_valid_d = 1'b1;
      case (CMD_CODE_IN)
        icsc_pkg::CMD_CFG10: begin
          rd_data_d = on_a ? {dgs_q, ceil_a_q} : {2'b00, boost_q, ofs_q, ceil_b_q};
        end
        icsc_pkg::CMD_CFG12: begin
          rd_data_d = on_a ? {sel_q, 1'b0, fact_q} : icsc_pkg::WORD_RST; // R12
        end
        icsc_pkg::CMD_IIN: begin
          rd_data_d = iin_q; // R01 R17
        end
        default: begin
          rd_data_d = on_a ? VOUT_LIN_A_IN : VOUT_LIN_B_IN; // R16
        end
      endcase
    end else if (RD_BYTE_IN && CMD_CODE_IN == icsc_pkg::CMD_PAGE) begin
      rd_valid_d = 1'b1;
      rd_data_d  = {8'h00, page_q};
    end else if (RD_WORD_IN || RD_BYTE_IN) begin
      invalid_d  = 1'b1; // R15
    end
    if (WR_WORD_IN) begin
      invalid_d = !is_known || CMD_CODE_IN == icsc_pkg::CMD_PAGE ||
                  CMD_CODE_IN == icsc_pkg::CMD_IIN || CMD_CODE_IN == icsc_pkg::CMD_VOUT_LIN; // R16
    end else if (WR_BYTE_IN) begin
      invalid_d = CMD_CODE_IN != icsc_pkg::CMD_PAGE ||
                  (WR_DATA_IN[7:0] != icsc_pkg::PAGE_A && WR_DATA_IN[7:0] != icsc_pkg::PAGE_B); // R15
    end
  end

  // Response registers
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      rd_data_q  <= icsc_pkg::WORD_RST;
      rd_valid_q <= 1'b0;
      invalid_q  <= 1'b0;
    end else if (CE_IN) begin
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      invalid_q  <= invalid_d;
    end
  end

  // Refresh timer and readback next values
  always_comb begin
    start_d   = 1'b0;
    ref_cnt_d = ref_cnt_q + 16'h0001;
    if (ref_cnt_q == 16'(REFRESH_CYCLES - 1)) begin // R17
      ref_cnt_d = 16'h0000;
      start_d   = 1'b1;
    end
    iin_d  = iin_q;
    clip_d = clip_q;
    upd_d  = 1'b0;
    if (calc_done) begin
      iin_d  = {icsc_pkg::LIN_EXP, calc_mant}; // R18
      clip_d = calc_clip;
      upd_d  = 1'b1;
    end
  end

  // Refresh and readback registers
  always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ref_cnt_q <= 16'h0000;
      start_q   <= 1'b0;
      iin_q     <= icsc_pkg::WORD_RST;
      clip_q    <= 1'b0;
      upd_q     <= 1'b0;
    end else if (CE_IN) begin
      ref_cnt_q <= ref_cnt_d;
      start_q   <= start_d;
      iin_q     <= iin_d;
      clip_q    <= clip_d;
      upd_q     <= upd_d;
    end
  end

  // Shared current computation for both channels
  icsc_calc u_calc (
    .clk_in       (REF_CLK_IN),
    .rst_in       (RESET_IN),
    .ce_in        (CE_IN),
    .start_in     (start_q),
    .uv_in        (SENSE_UV_IN),
    .gain_code_in ({boost_q, sel_q}),
    .dgs_in       (dgs_q),
    .ofs_in       (ofs_q),
    .done_out     (calc_done),
    .mant_out     (calc_mant),
    .clip_out     (calc_clip)
  );

  // Outputs straight from registers
  assign RD_DATA_OUT          = rd_data_q;
  assign RD_VALID_OUT         = rd_valid_q;
  assign INVALID_OUT          = invalid_q;
  assign IIN_WORD_OUT         = iin_q;
  assign IIN_UPDATE_OUT       = upd_q;
  assign SENSE_CLIP_OUT       = clip_q;
  assign ANALOG_GAIN_CODE_OUT = {boost_q, sel_q};
  assign CEIL_A_OUT           = ceil_a_q;
  assign CEIL_B_OUT           = ceil_b_q;
  assign PAGE_OUT             = page_q;

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RESET_IN);

  property p_dgs_limit;
    (CE_IN && !load_pend_q && on_a && WR_WORD_IN && CMD_CODE_IN == icsc_pkg::CMD_CFG10 && WR_DATA_IN[15:8] > 8'h40)
      |=> (RD_VALID_OUT == 1'b0) ##0 (ANALOG_GAIN_CODE_OUT == $past(ANALOG_GAIN_CODE_OUT)) ##0 (dgs_q == 8'h40);
  endproperty
  a_dgs_limit: assert property (p_dgs_limit) else $error("gain scale above 64 not limited"); // R05

  property p_ceil_b;
    (CE_IN && !load_pend_q && !on_a && WR_WORD_IN && CMD_CODE_IN == icsc_pkg::CMD_CFG10)
      |=> (CEIL_B_OUT == $past(WR_DATA_IN[7:0]) && CEIL_A_OUT == $past(CEIL_A_OUT)
           && ANALOG_GAIN_CODE_OUT[2] == $past(WR_DATA_IN[13]));
  endproperty
  a_ceil_b: assert property (p_ceil_b) else $error("page 1 write did not reach channel B fields"); // R10

  property p_sel_page1;
    (CE_IN && !load_pend_q && !on_a && WR_WORD_IN && CMD_CODE_IN == icsc_pkg::CMD_CFG12)
      |=> $stable(ANALOG_GAIN_CODE_OUT[1:0]);
  endproperty
  a_sel_page1: assert property (p_sel_page1) else $error("gain select changed by page 1 write"); // R12

  property p_ro_write;
    (CE_IN && WR_WORD_IN && (CMD_CODE_IN == icsc_pkg::CMD_VOUT_LIN || CMD_CODE_IN == icsc_pkg::CMD_IIN))
      |=> INVALID_OUT && $stable(IIN_WORD_OUT[15:11]);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("write to readback not refused"); // R16

  property p_byte_refused;
    (CE_IN && (WR_BYTE_IN || RD_BYTE_IN) && CMD_CODE_IN == icsc_pkg::CMD_CFG10) |=> INVALID_OUT && !RD_VALID_OUT;
  endproperty
  a_byte_refused: assert property (p_byte_refused) else $error("byte access to word register accepted"); // R15

  property p_refresh_gap;
    (start_q && CE_IN) |=> !start_q[*3];
  endproperty
  a_refresh_gap: assert property (p_refresh_gap) else $error("refresh started too soon"); // R17

  property p_refresh_count;
    start_q |-> $past(ref_cnt_q) == 16'(REFRESH_CYCLES - 1) || !$past(CE_IN);
  endproperty
  a_refresh_count: assert property (p_refresh_count) else $error("refresh period count wrong"); // R17

  property p_word_format;
    upd_q |-> IIN_WORD_OUT[15:11] == 5'h1C;
  endproperty
  a_word_format: assert property (p_word_format) else $error("input current exponent wrong"); // R18

  property p_load;
    (load_pend_q && CE_IN) |=> !load_pend_q && CEIL_A_OUT == $past(NVM_CFG_A_IN[7:0])
                              && ANALOG_GAIN_CODE_OUT == {$past(NVM_CFG_B_IN[13]), $past(NVM_GAIN_IN[15:14])};
  endproperty
  a_load: assert property (p_load) else $error("stored defaults not loaded"); // R20

  property p_input_current_readback;
    (CE_IN && RD_WORD_IN && CMD_CODE_IN == icsc_pkg::CMD_IIN) |=> RD_VALID_OUT && RD_DATA_OUT == $past(iin_q);
  endproperty
  a_input_current_readback: assert property (p_input_current_readback) else $error("input current read returned wrong word"); // R01
endmodule

/* File: dv/icsc_host.sv */
// Purpose: Host model issuing word and byte transactions
// Assumes: Answer stands in the cycle after the taking edge
// Notes:   Drives at a falling edge, samples at the next one
`timescale 1ns/1ps
module icsc_host (
  // Clock
  input  wire logic        clk_in,
  // Answers
  input  wire logic [15:0] rd_data_in,
  input  wire logic        rd_valid_in,
  input  wire logic        invalid_in,
  // Requests
  output logic [7:0]       cmd_out,
  output logic             wr_word_out,
  output logic             rd_word_out,
  output logic             wr_byte_out,
  output logic             rd_byte_out,
  output logic [15:0]      wr_data_out
);
  // Idle request lines
  initial begin
    cmd_out = 8'h00;
    {wr_word_out, rd_word_out, wr_byte_out, rd_byte_out} = 4'h0;
    wr_data_out = 16'h0000;
  end
  // Kind 0 write word, 1 read word, 2 write byte, 3 read byte
  task automatic xfer(input logic [1:0] kind, input logic [7:0] cmd, input logic [15:0] data,
                      output logic [15:0] rdat, output logic ok, output logic bad);
    @(negedge clk_in);
    cmd_out     = cmd;
    wr_data_out = data;
    wr_word_out = (kind == 2'd0);
    rd_word_out = (kind == 2'd1);
    wr_byte_out = (kind == 2'd2);
    rd_byte_out = (kind == 2'd3);
    @(negedge clk_in);
    rdat = rd_data_in;
    ok   = rd_valid_in;
    bad  = invalid_in;
    {wr_word_out, rd_word_out, wr_byte_out, rd_byte_out} = 4'h0;
    wr_data_out = ~data; // Stale data never looks valid
  endtask
  // Page select
  task automatic set_page(input logic [7:0] pg);
    logic [15:0] rdat;
    logic        ok;
    logic        bad;
    xfer(2'd2, icsc_pkg::CMD_PAGE, {8'h00, pg}, rdat, ok, bad);
  endtask
  // New gain select, factory bits kept
  task automatic set_select(input logic [1:0] sel);
    logic [15:0] rdat;
    logic        ok;
    logic        bad;
    set_page(icsc_pkg::PAGE_A);
    xfer(2'd1, icsc_pkg::CMD_CFG12, 16'h0000, rdat, ok, bad);
    xfer(2'd0, icsc_pkg::CMD_CFG12, {sel, rdat[13:0]}, rdat, ok, bad);
  endtask
  // Scale for a sense element between gain steps
  function automatic logic [7:0] scale_for(input int gain_uohm, input int rsense_uohm);
    return 8'(50 * gain_uohm / rsense_uohm);
  endfunction
endmodule

/* File: dv/tb_top.sv */
// Purpose: Self-checking bench for input current calibration
// Assumes: Refresh shortened to 8 cycles
// Notes:   Stimulus changes at falling edges only
`timescale 1ns/1ps
module tb_top;
  // Stimulus and observed signals
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               ce = 1'b1;
  logic [15:0]        nvm_a = 16'h3214;
  logic [15:0]        nvm_b = 16'h2A07;
  logic [15:0]        nvm_g = 16'hC123;
  logic signed [15:0] uv = 16'sh0000;
  logic [15:0]        vout_a = 16'hE123;
  logic [15:0]        vout_b = 16'hD456;
  logic [15:0]        rd_data, iin_word, wr_d, rdat;
  logic [7:0]         cmd, ceil_a, ceil_b, page;
  logic [2:0]         gcode;
  logic               rd_valid, invalid, iin_upd, clip, wr_w, rd_w, wr_b, rd_b, ok, bad;
  int                 n_mismatch = 0;
  int                 comparisons = 0;
  int                 cyc;
  // Case tables
  logic [15:0]        fs_uv [4] = '{16'h1D4C, 16'h30D4, 16'h3A98, 16'h61A8};
  logic [4:0]         ofs_code [4] = '{5'h0A, 5'h0F, 5'h10, 5'h1F};
  logic [10:0]        ofs_mant [4] = '{11'h010, 11'h018, 11'h7E6, 11'h7FE};
  logic [1:0]         bad_kind [7] = '{2'd0, 2'd0, 2'd0, 2'd1, 2'd1, 2'd3, 2'd2};
  logic [7:0]         bad_cmd [7] = '{8'h00, 8'h89, 8'hD4, 8'h00, 8'h55, 8'hDA, 8'h00};

  always #50 clk = ~clk;

  icsc_top #(.REFRESH_CYCLES(8)) icsc_top_i (
    .REF_CLK_IN(clk), .RESET_IN(rst), .CE_IN(ce), .CMD_CODE_IN(cmd), .WR_WORD_IN(wr_w), .RD_WORD_IN(rd_w),
    .WR_BYTE_IN(wr_b), .RD_BYTE_IN(rd_b), .WR_DATA_IN(wr_d), .RD_DATA_OUT(rd_data), .RD_VALID_OUT(rd_valid),
    .INVALID_OUT(invalid), .NVM_CFG_A_IN(nvm_a), .NVM_CFG_B_IN(nvm_b), .NVM_GAIN_IN(nvm_g), .SENSE_UV_IN(uv),
    .VOUT_LIN_A_IN(vout_a), .VOUT_LIN_B_IN(vout_b), .IIN_WORD_OUT(iin_word), .IIN_UPDATE_OUT(iin_upd),
    .SENSE_CLIP_OUT(clip), .ANALOG_GAIN_CODE_OUT(gcode), .CEIL_A_OUT(ceil_a), .CEIL_B_OUT(ceil_b), .PAGE_OUT(page));
  icsc_host icsc_host_i (.clk_in(clk), .rd_data_in(rd_data), .rd_valid_in(rd_valid), .invalid_in(invalid),
    .cmd_out(cmd), .wr_word_out(wr_w), .rd_word_out(rd_w), .wr_byte_out(wr_b), .rd_byte_out(rd_b), .wr_data_out(wr_d));

  // Compare and count
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Word write and checked word read
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    icsc_host_i.xfer(2'd0, c, d, rdat, ok, bad);
  endtask
  task automatic rd(input string what, input logic [7:0] c, input logic [15:0] exp);
    icsc_host_i.xfer(2'd1, c, 16'h0000, rdat, ok, bad);
    chk({what, " valid"}, 16'h0001, {15'h0000, ok});
    chk(what, exp, rdat);
  endtask
  // Next refresh pulse, cycles counted
  task automatic wait_upd();
    cyc = 0;
    do begin
      @(negedge clk);
      cyc++;
    end while (iin_upd !== 1'b1 && cyc < 40);
    if (iin_upd !== 1'b1) begin
      n_mismatch++;
    end
  endtask
  // Sense sample applied, reported current checked
  task automatic iin(input string what, input logic signed [15:0] v, input logic [10:0] mant);
    @(negedge clk);
    uv = v;
    wait_upd();
    wait_upd();
    chk(what, {icsc_pkg::LIN_EXP, mant}, iin_word);
    rd({what, " read"}, icsc_pkg::CMD_IIN, {icsc_pkg::LIN_EXP, mant});
  endtask
  // Counts, verdict, end of run
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk("ceiling a", 16'h0014, {8'h00, ceil_a});
    chk("ceiling b", 16'h0007, {8'h00, ceil_b});
    chk("gain code", 16'h0007, {13'h0000, gcode});
    rd("cfg page 0", icsc_pkg::CMD_CFG10, 16'h3214);
    rd("gain word", icsc_pkg::CMD_CFG12, 16'hC123);
    icsc_host_i.set_page(icsc_pkg::PAGE_B);
    chk("page", 16'h0001, {8'h00, page});
    rd("cfg page 1", icsc_pkg::CMD_CFG10, 16'h2A07);
    rd("gain page 1", icsc_pkg::CMD_CFG12, 16'h0000);
    wr(icsc_pkg::CMD_CFG12, 16'h4000);
    wr(icsc_pkg::CMD_CFG10, 16'h0033);
    chk("ceiling b new", 16'h0033, {8'h00, ceil_b});
    chk("ceiling a kept", 16'h0014, {8'h00, ceil_a});
    icsc_host_i.set_page(icsc_pkg::PAGE_A);
    rd("gain kept", icsc_pkg::CMD_CFG12, 16'hC123);
    wr(icsc_pkg::CMD_CFG10, 16'h4820);
    rd("scale clamp", icsc_pkg::CMD_CFG10, 16'h4020);
    wr(icsc_pkg::CMD_CFG10, 16'h3214);
    // Every gain code at its full-scale sense voltage
    for (int g = 0; g < 8; g++) begin
      icsc_host_i.set_page(icsc_pkg::PAGE_B);
      wr(icsc_pkg::CMD_CFG10, {2'b00, g[2], 13'h0033});
      icsc_host_i.set_select(g[1:0]);
      chk("gain code", {13'h0000, g[2:0]}, {13'h0000, gcode});
      iin("full scale", fs_uv[g[1:0]], g[2] ? 11'd100 : 11'd800);
    end
    icsc_host_i.set_page(icsc_pkg::PAGE_B);
    wr(icsc_pkg::CMD_CFG10, 16'h0033);
    iin("over range", 16'sd30000, 11'd800);
    chk("clip set", 16'h0001, {15'h0000, clip});
    wait_upd();
    wait_upd();
    chk("period", 16'd8, cyc[15:0]);
    // Signed offset codes at zero sense voltage
    foreach (ofs_code[i]) begin
      wr(icsc_pkg::CMD_CFG10, {3'b000, ofs_code[i], 8'h33});
      iin("offset", 16'sd0, ofs_mant[i]);
    end
    wr(icsc_pkg::CMD_CFG10, 16'h0033);
    icsc_host_i.set_page(icsc_pkg::PAGE_A);
    wr(icsc_pkg::CMD_CFG10, {icsc_host_i.scale_for(500, 1000), 8'h14});
    iin("half scale", 16'sd25000, 11'd400);
    chk("clip clear", 16'h0000, {15'h0000, clip});
    // Refused transactions leave state alone
    foreach (bad_kind[i]) begin
      icsc_host_i.xfer(bad_kind[i], bad_cmd[i], 16'h0002, rdat, ok, bad);
      chk("refused", 16'h0001, {15'h0000, bad});
      chk("refused valid", 16'h0000, {15'h0000, ok});
    end
    chk("page kept", 16'h0000, {8'h00, page});
    rd("vout a", icsc_pkg::CMD_VOUT_LIN, 16'hE123);
    icsc_host_i.set_page(icsc_pkg::PAGE_B);
    rd("vout b", icsc_pkg::CMD_VOUT_LIN, 16'hD456);
    // Second reset reloads stored words
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    rd("cfg reload", icsc_pkg::CMD_CFG10, 16'h3214);
    wrap_up();
  end

  // Watchdog
  initial begin
    #1000000;
    n_mismatch++;
    wrap_up();
  end
endmodule
